/* File: rtl/lfg_regs.svh */
`ifndef LFG_REGS_SVH
`define LFG_REGS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define LFG_CLK_MHZ        100
`define LFG_WAKE_MIN_US    30
`define LFG_WAKE_MAX_US    150
// Least time: 30 us at 100 MHz is an exact whole number of cycles
`define LFG_WAKE_CYCLES    (`LFG_WAKE_MIN_US * `LFG_CLK_MHZ)
`define LFG_WAKE_MAX_CYC   (`LFG_WAKE_MAX_US * `LFG_CLK_MHZ)
`define LFG_CLAMP_DET_US   10
`define LFG_CLAMP_CYCLES   (`LFG_CLAMP_DET_US * `LFG_CLK_MHZ)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LFG_RST_LEVEL      1'h1

`endif

/* File: rtl/lfg_pkg.sv */
package lfg_pkg;

    // Line mode selected by the host
    typedef enum logic [1:0] {
        LFG_MODE_OFF    = 2'h0,
        LFG_MODE_WAKE   = 2'h1,
        LFG_MODE_NORMAL = 2'h2,
        LFG_MODE_RXONLY = 2'h3
    } lfg_mode_t;

    // Transmitter guard states
    typedef enum logic [2:0] {
        LFG_TX_RUN  = 3'h1,
        LFG_TX_HOT  = 3'h2,
        LFG_TX_WAIT = 3'h4
    } lfg_tx_state_t;

    typedef struct packed {
        lfg_tx_state_t fsm;
        lfg_mode_t     mode;
        logic          ot_m;
        logic          ot_s;
        logic          txd;
        logic          txd_prev;
        logic          bus;
        logic          bus_prev;
        logic          sense;
        logic          rxd;
        logic          drv_en;
        logic          drv_dom;
        logic          clamp_present;
        logic          clamp_flag;
        logic          wake;
        logic          wake_done;
    } lfg_state_t;

endpackage

/* File: rtl/lfg_dom_timer.sv */
`timescale 1ns/1ns
`default_nettype none

// Counts consecutive cycles of run; done once CYCLES have passed
module lfg_dom_timer #(
    parameter int CYCLES = 3000
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic run_i,
    output var  logic done_o
);
    localparam int W = $clog2(CYCLES + 1);

    if (CYCLES < 1) begin : g_chk
        $error("lfg_dom_timer: CYCLES must be at least 1");
    end

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (!run_i) begin
            next_cnt = '0;
        end else if (cnt != W'(CYCLES)) begin
            next_cnt = cnt + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt    <= '0;
            done_o <= 1'h0;
        end else begin
            cnt    <= next_cnt;
            done_o <= (next_cnt == W'(CYCLES));
        end
    end

endmodule

`default_nettype wire

/* File: rtl/lfg_guard.sv */
// Functional notes
// R1: Overtemperature disables the bus driver immediately; here DRIVER_EN_O drops on the third clock edge after OVERTEMP_I rises.
// R2: Overtemperature falls back to receive-only; bus levels still reach receive output.
// R3: After cooling, driving resumes only after a transmit dominant-to-recessive edge.
// R4: Overtemperature sets no diagnostic flag and raises no interrupt.
// R5: Receive output stuck recessive during bus activity is flagged as diagnosed fault.
// R6: Driver stays off while the stuck-recessive fault persists.
// R7: After stuck-recessive fault, driver stays off until host re-enable command.
// R8: In wake mode a dominant phase wakes only if longer than filter time.
// R9: Receive-only mode keeps driver off and still reflects bus levels.
// R10: Bus wake only on dominant-to-recessive edge; shorted bus never wakes.
// R11: Thermal flag synchronised; transmit release from synchronised transmit edge.
`timescale 1ns/1ns
`default_nettype none
`include "lfg_regs.svh"

module lfg_guard
    import lfg_pkg::*;
#(
    parameter int WAKE_CYCLES  = `LFG_WAKE_CYCLES,
    parameter int CLAMP_CYCLES = `LFG_CLAMP_CYCLES
) (
    input  wire logic       REF_CLK_I,
    input  wire logic       RESET_N_I,
    input  wire logic [1:0] MODE_I,
    input  wire logic       TXD_I,
    input  wire logic       BUS_RX_I,
    input  wire logic       RXD_SENSE_I,
    input  wire logic       OVERTEMP_I,
    input  wire logic       TX_REENABLE_I,
    output var  logic       RXD_O,
    output var  logic       DRIVER_EN_O,
    output var  logic       BUS_DRIVE_O,
    output var  logic       RX_CLAMP_FAULT_O,
    output var  logic       WAKE_O
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > `LFG_WAKE_MAX_CYC) begin : g_chk_wake
        $error("lfg_guard: WAKE_CYCLES outside the wake filter window");
    end
    if (CLAMP_CYCLES < 1) begin : g_chk_clamp
        $error("lfg_guard: CLAMP_CYCLES must be at least 1");
    end

    lfg_state_t s;
    lfg_state_t next_s;
    logic       wake_long;
    logic       clamp_seen;
    logic       txd_release;
    logic       bus_release;

    // ----------------------------------------------------------------
    // Dominant-time filters
    // ----------------------------------------------------------------
    lfg_dom_timer #(
        .CYCLES (WAKE_CYCLES)
    ) u_wake_filter (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RESET_N_I),
        .run_i   ((s.mode == LFG_MODE_WAKE) && !s.bus),
        .done_o  (wake_long)
    );

    // Bus dominant while the receive pin still reads recessive
    lfg_dom_timer #(
        .CYCLES (CLAMP_CYCLES)
    ) u_clamp_filter (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RESET_N_I),
        .run_i   (!s.bus && s.sense && !s.rxd),
        .done_o  (clamp_seen)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    assign txd_release = !s.txd_prev && s.txd;                           // R11
    assign bus_release = !s.bus_prev && s.bus;

    always_comb begin
        next_s          = s;
        next_s.mode     = lfg_mode_t'(MODE_I);
        next_s.ot_m     = OVERTEMP_I;                                    // R11
        next_s.ot_s     = s.ot_m;                                        // R11
        next_s.txd      = TXD_I;
        next_s.txd_prev = s.txd;
        next_s.bus      = BUS_RX_I;
        next_s.bus_prev = s.bus;
        next_s.sense    = RXD_SENSE_I;

        case (s.fsm)
            LFG_TX_RUN: begin
                if (s.ot_s) begin
                    next_s.fsm = LFG_TX_HOT;                             // R1
                end
            end
            LFG_TX_HOT: begin
                if (!s.ot_s) begin
                    next_s.fsm = LFG_TX_WAIT;
                end
            end
            LFG_TX_WAIT: begin
                if (s.ot_s) begin
                    next_s.fsm = LFG_TX_HOT;
                end else if (txd_release) begin
                    next_s.fsm = LFG_TX_RUN;                             // R3
                end
            end
            default: begin
                next_s.fsm = LFG_TX_RUN;
            end
        endcase

        // Fault lasts until the receive pin is seen following a dominant bus
        if (clamp_seen) begin
            next_s.clamp_present = 1'h1;                                 // R6
        end else if (!s.bus && !s.sense) begin
            next_s.clamp_present = 1'h0;
        end

        // Detection wins over a re-enable in the same cycle
        if (clamp_seen) begin
            next_s.clamp_flag = 1'h1;                                    // R5
        end else if (TX_REENABLE_I && !s.clamp_present) begin
            next_s.clamp_flag = 1'h0;                                    // R7
        end

        // Overtemperature feeds no flag here: it only steers the state above
        next_s.drv_en  = (s.mode == LFG_MODE_NORMAL) && (next_s.fsm == LFG_TX_RUN)
                         && !next_s.clamp_flag;                          // R1 R4 R6 R7 R9
        next_s.drv_dom = next_s.drv_en && !s.txd;

        // Wake fires once per entry into wake mode
        next_s.wake = 1'h0;
        if (s.mode != LFG_MODE_WAKE) begin
            next_s.wake_done = 1'h0;
        end else if (!s.wake_done && bus_release && wake_long) begin
            next_s.wake      = 1'h1;                                     // R8 R10
            next_s.wake_done = 1'h1;
        end

        if (s.mode == LFG_MODE_NORMAL || s.mode == LFG_MODE_RXONLY) begin
            next_s.rxd = s.bus;                                          // R2 R9
        end else begin
            next_s.rxd = !(s.wake_done || next_s.wake);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            s          <= '0;
            s.fsm      <= LFG_TX_RUN;
            s.txd      <= `LFG_RST_LEVEL;
            s.txd_prev <= `LFG_RST_LEVEL;
            s.bus      <= `LFG_RST_LEVEL;
            s.bus_prev <= `LFG_RST_LEVEL;
            s.rxd      <= `LFG_RST_LEVEL;
        end else begin
            s <= next_s;
        end
    end

    assign RXD_O            = s.rxd;
    assign DRIVER_EN_O      = s.drv_en;
    assign BUS_DRIVE_O      = s.drv_dom;
    assign RX_CLAMP_FAULT_O = s.clamp_flag;
    assign WAKE_O           = s.wake;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    ot_driver_off_a: assert property (s.ot_s |=> !DRIVER_EN_O && !BUS_DRIVE_O) // R1
        else $error("driver still enabled during overtemperature");

    ot_rx_path_a: assert property ((s.fsm == LFG_TX_HOT) && (s.mode == LFG_MODE_NORMAL)
                                   |=> RXD_O == $past(s.bus)) // R2
        else $error("receive output not following bus while hot");

    cool_wait_a: assert property ((s.fsm == LFG_TX_WAIT) && !txd_release |=> !DRIVER_EN_O) // R3
        else $error("driver released without transmit edge");

    cool_release_a: assert property ((s.fsm == LFG_TX_WAIT) && txd_release && !s.ot_s
                                     && (s.mode == LFG_MODE_NORMAL) && !s.clamp_flag && !clamp_seen
                                     |=> DRIVER_EN_O) // R3
        else $error("driver not released on transmit edge");

    ot_no_diag_a: assert property ($rose(RX_CLAMP_FAULT_O) |-> $past(clamp_seen)) // R4
        else $error("diagnostic flag set without clamp detection");

    clamp_detect_a: assert property (clamp_seen |=> RX_CLAMP_FAULT_O ##1 RX_CLAMP_FAULT_O) // R5
        else $error("clamp fault not flagged");

    clamp_block_a: assert property (s.clamp_present |=> !DRIVER_EN_O) // R6
        else $error("driver enabled while clamp persists");

    clamp_hold_a: assert property (RX_CLAMP_FAULT_O && !TX_REENABLE_I |=> RX_CLAMP_FAULT_O) // R7
        else $error("clamp fault cleared without command");

    clamp_clear_a: assert property (RX_CLAMP_FAULT_O && TX_REENABLE_I && !s.clamp_present
                                    && !clamp_seen |=> !RX_CLAMP_FAULT_O) // R7
        else $error("re-enable command ignored");

    wake_filter_a: assert property (WAKE_O |-> $past(wake_long) && $past(s.mode) == LFG_MODE_WAKE) // R8
        else $error("wake without long dominant phase");

    wake_edge_a: assert property (WAKE_O |-> $past(s.bus) && !$past(s.bus_prev)) // R10
        else $error("wake not on recessive edge");

    rxonly_off_a: assert property ((s.mode == LFG_MODE_RXONLY) |=> !DRIVER_EN_O
                                   && RXD_O == $past(s.bus)) // R9
        else $error("receive-only mode misbehaves");

    cov_ot_release: cover property ((s.fsm == LFG_TX_WAIT) ##1 (s.fsm == LFG_TX_RUN));
    cov_clamp_clear: cover property (RX_CLAMP_FAULT_O ##1 !RX_CLAMP_FAULT_O);
    cov_wake: cover property (WAKE_O);
    cov_drive: cover property (BUS_DRIVE_O);

endmodule

`default_nettype wire

/* File: dv/lfg_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Far side: wired bus with pull-up, and the receive pin read-back
// ----------------------------------------------------------------
// The pull-up makes the bus recessive once nobody drives it
module lfg_bus_model (
    input  wire logic remote_dom_i,
    input  wire logic drive_i,
    input  wire logic rxd_i,
    input  wire logic stuck_i,
    output var  logic bus_rx_o,
    output var  logic rxd_sense_o
);
    always_comb begin
        bus_rx_o    = !(remote_dom_i || drive_i);
        rxd_sense_o = stuck_i ? 1'h1 : rxd_i;
    end
endmodule

`default_nettype wire

/* File: dv/lfg_guard_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module lfg_guard_tb;
    import lfg_pkg::*;

    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] val;
    } lfg_exp_t;

    logic       clk   = 1'h0;
    logic       rst_n = 1'h0;
    logic [1:0] mode  = 2'h2;
    logic       txd   = 1'h1;
    logic       ot    = 1'h0;
    logic       reen  = 1'h0;
    logic       rdom  = 1'h0;
    logic       stuck = 1'h0;
    logic       bus_rx, sense, rxd, en, drv, fault, wake;
    int         n_errors = 0;
    int         checks   = 0;
    int         wake_cnt = 0;
    lfg_exp_t   q[$];
    string      names[6] = '{"rxd", "drv_en", "bus_drive", "fault", "wake", "wake_count"};

    always #5 clk = ~clk;

    lfg_guard #(.WAKE_CYCLES(8), .CLAMP_CYCLES(4)) dut (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .MODE_I(mode), .TXD_I(txd),
        .BUS_RX_I(bus_rx), .RXD_SENSE_I(sense), .OVERTEMP_I(ot), .TX_REENABLE_I(reen),
        .RXD_O(rxd), .DRIVER_EN_O(en), .BUS_DRIVE_O(drv), .RX_CLAMP_FAULT_O(fault), .WAKE_O(wake)
    );

    lfg_bus_model far (.remote_dom_i(rdom), .drive_i(drv), .rxd_i(rxd), .stuck_i(stuck),
        .bus_rx_o(bus_rx), .rxd_sense_o(sense));

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    function automatic logic [7:0] get(input logic [2:0] s);
        case (s)
            3'h0: return {7'h0, rxd};
            3'h1: return {7'h0, en};
            3'h2: return {7'h0, drv};
            3'h3: return {7'h0, fault};
            3'h4: return {7'h0, wake};
            default: return wake_cnt[7:0];
        endcase
    endfunction

    task automatic check(input logic [2:0] s, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", names[s], exp, seen);
        end
    endtask

    task automatic expect_out(input logic [2:0] s, input logic [7:0] v);
        q.push_back('{s, v});
    endtask

    // Outputs are settled at the falling edge
    always @(negedge clk) begin
        lfg_exp_t e;
        while (q.size() > 0) begin
            e = q.pop_front();
            check(e.sel, get(e.sel), e.val);
        end
    end

    always @(posedge clk) begin
        if (wake === 1'h1) begin
            wake_cnt <= wake_cnt + 1;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_out(input logic [2:0] s, input logic [7:0] v);
        int i;
        for (i = 0; i < 40 && get(s) !== v; i++) step(1);
        if (i == 40) begin
            n_errors++;
            $display("unexpected timeout on %s: expected %h seen %h", names[s], v, get(s));
            test_done();
        end else begin
            expect_out(s, v);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h3c22a135));
        step(2);
        for (int k = 0; k < 5; k++) expect_out(k[2:0], {7'h0, k == 0});
        step(1);
        rst_n = 1'h1;
        $display("test reset done");
        wait_out(3'h1, 8'h1);
        for (int k = 0; k < 8; k++) begin
            {rdom, txd} = 2'($urandom);
            step(4);
            expect_out(3'h2, {7'h0, !txd});
            expect_out(3'h0, {7'h0, !(rdom || !txd)});
        end
        $display("test normal done");
        txd = 1'h0;
        ot  = 1'h1;
        step(3);
        expect_out(3'h1, 8'h0);
        expect_out(3'h2, 8'h0);
        rdom = 1'h1;
        txd  = 1'h1;
        step(3);
        expect_out(3'h0, 8'h0);
        expect_out(3'h3, 8'h0);
        rdom = 1'h0;
        ot   = 1'h0;
        step(6);
        expect_out(3'h1, 8'h0);
        txd = 1'h0;
        step(1);
        txd = 1'h1;
        wait_out(3'h1, 8'h1);
        $display("test overtemp done");
        stuck = 1'h1;
        rdom  = 1'h1;
        wait_out(3'h3, 8'h1);
        expect_out(3'h1, 8'h0);
        reen = 1'h1;
        step(1);
        reen = 1'h0;
        step(2);
        expect_out(3'h3, 8'h1);
        expect_out(3'h1, 8'h0);
        stuck = 1'h0;
        step(3);
        expect_out(3'h1, 8'h0);
        reen = 1'h1;
        step(1);
        reen = 1'h0;
        wait_out(3'h3, 8'h0);
        wait_out(3'h1, 8'h1);
        rdom = 1'h0;
        $display("test stuck done");
        mode = 2'h3;
        for (int k = 0; k < 6; k++) begin
            {rdom, txd} = 2'($urandom);
            step(4);
            expect_out(3'h1, 8'h0);
            expect_out(3'h0, {7'h0, !rdom});
        end
        $display("test rxonly done");
        mode = 2'h1;
        rdom = 1'h0;
        txd  = 1'h1;
        step(4);
        expect_out(3'h0, 8'h1);
        rdom = 1'h1;
        step(7);
        rdom = 1'h0;
        step(8);
        expect_out(3'h5, 8'h0);
        rdom = 1'h1;
        step(40);
        expect_out(3'h5, 8'h0);
        rdom = 1'h0;
        step(4);
        expect_out(3'h5, 8'h1);
        expect_out(3'h0, 8'h0);
        step(2);
        $display("test wake done");
        mode = 2'h0;
        step(4);
        expect_out(3'h0, 8'h1);
        rdom = 1'h1;
        step(12);
        rdom = 1'h0;
        step(4);
        expect_out(3'h5, 8'h1);
        expect_out(3'h0, 8'h1);
        $display("test off done");
        test_done();
    end
endmodule

`default_nettype wire
